// ---- pwm_regs.svh ----
// offsets, field positions, fixed values and reset values of the
// power-management capability registers in configuration space.
// assumes byte addressing of configuration space, dword-wide read data.
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

`define PWM_HDR_OFS 8'h44
`define PWM_CAPW_OFS 8'h46
`define PWM_DW_INDEX 6'h11

`define PWM_HDR_RESET 16'h0001
`define PWM_CAPW_RESET 16'h7e02

`define PWM_NEXT_PTR_VAL 8'h00
`define PWM_CAP_ID_VAL 8'h01

`define PWM_COLD_BIT 15
`define PWM_SRC_MSB 14
`define PWM_SRC_LSB 11
`define PWM_SRC_VAL 4'hf
`define PWM_D2_BIT 10
`define PWM_D1_BIT 9
`define PWM_AUX_MSB 8
`define PWM_AUX_LSB 6
`define PWM_AUX_SELF 3'h0
`define PWM_AUX_55MA 3'h1
`define PWM_DSI_BIT 5
`define PWM_RSVD_BIT 4
`define PWM_CLK_BIT 3
`define PWM_REV_MSB 2
`define PWM_REV_LSB 0
`define PWM_REV_VAL 3'h2

`endif

// ---- pwm_pkg.sv ----
// types shared by the power-management capability block.
// assumes pwm_regs.svh supplies the numeric constants.
package pwm_pkg;

   typedef logic [15:0] pwm_word_t;
   typedef logic [31:0] pwm_dword_t;
   typedef logic [7:0] pwm_addr_t;

   // kind of the access answered in the current cycle
   typedef enum logic [1:0] {
      PWM_ACC_NONE,
      PWM_ACC_READ,
      PWM_ACC_WRITE
   } pwm_acc_t;

endpackage : pwm_pkg

// ---- pwm_cap.sv ----
// power-management capability header and capabilities word, read over
// the configuration access port of the controller.
// assumes one configuration request per cycle at most, synchronous to
// clk_sys; the host picks its byte lanes out of the returned dword.
`timescale 1ns/10ps
`include "pwm_regs.svh"

module pwm_cap
   import pwm_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire pwm_addr_t cfg_addr,
   input wire pwm_dword_t cfg_wdata,
   input wire logic cold_wake_load,
   input wire logic cold_wake_value,
   output pwm_dword_t cfg_rdata,
   output logic cfg_ack,
   output logic cfg_hit,
   output pwm_acc_t cfg_acc,
   output logic wake_from_cold_off
);

   // capabilities word as a function of the cold-wake bit alone
   function automatic pwm_word_t capw_value(input logic cold);
      pwm_word_t w;
      w = 16'h0000;
      w[`PWM_COLD_BIT] = cold;
      w[`PWM_SRC_MSB:`PWM_SRC_LSB] = `PWM_SRC_VAL;
      w[`PWM_D2_BIT] = 1'b1;
      w[`PWM_D1_BIT] = 1'b1;
      w[`PWM_AUX_MSB:`PWM_AUX_LSB] = cold ? `PWM_AUX_55MA : `PWM_AUX_SELF;
      w[`PWM_DSI_BIT] = 1'b0;
      w[`PWM_RSVD_BIT] = 1'b0;
      w[`PWM_CLK_BIT] = 1'b0;
      w[`PWM_REV_MSB:`PWM_REV_LSB] = `PWM_REV_VAL;
      return w;
   endfunction : capw_value

   function automatic pwm_word_t hdr_value();
      return {`PWM_NEXT_PTR_VAL, `PWM_CAP_ID_VAL};
   endfunction : hdr_value

   // decode: both 16-bit registers share one configuration dword
   wire logic dw_sel;
   wire logic any_req;
   wire pwm_dword_t dw_data;
   wire pwm_dword_t next_rdata;
   wire pwm_acc_t next_acc;
   wire logic next_cold;

   assign dw_sel = (cfg_addr[7:2] == `PWM_DW_INDEX);
   assign any_req = cfg_rd | cfg_wr;
   assign dw_data = {capw_value(wake_from_cold_off), hdr_value()};
   // writes never reach storage; read wins if both strobes are high
   assign next_rdata = (cfg_rd && dw_sel) ? dw_data : 32'h0000_0000;
   assign next_acc = cfg_rd ? PWM_ACC_READ : (cfg_wr ? PWM_ACC_WRITE : PWM_ACC_NONE);
   // only the internal load path may move the cold-wake bit
   assign next_cold = cold_wake_load ? cold_wake_value : wake_from_cold_off;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wake_from_cold_off <= 1'b0;
      end else begin
         wake_from_cold_off <= next_cold;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rdata <= 32'h0000_0000;
         cfg_ack <= 1'b0;
         cfg_hit <= 1'b0;
         cfg_acc <= PWM_ACC_NONE;
      end else begin
         cfg_rdata <= next_rdata;
         cfg_ack <= any_req;
         cfg_hit <= any_req & dw_sel;
         cfg_acc <= next_acc;
      end
   end

   // write data is accepted and dropped; kept only so the port is observed
   wire logic wr_data_seen;
   assign wr_data_seen = cfg_wr & (|cfg_wdata);

   // answered dword split into its fields, read only by the checks below
   wire logic [7:0] rd_next_ptr;
   wire logic [7:0] rd_cap_list_identifier;
   wire logic rd_wake_from_cold_off;
   wire logic [3:0] rd_wake_source_states;
   wire logic rd_deep_doze_supported;
   wire logic rd_light_doze_supported;
   wire logic [2:0] rd_aux_current;
   wire logic rd_init_needed;
   wire logic rd_reserved;
   wire logic rd_wake_needs_bus_clock;
   wire logic [2:0] rd_power_spec_revision;
   assign rd_next_ptr = cfg_rdata[15:8];
   assign rd_cap_list_identifier = cfg_rdata[7:0];
   assign rd_wake_from_cold_off = cfg_rdata[31];
   assign rd_wake_source_states = cfg_rdata[30:27];
   assign rd_deep_doze_supported = cfg_rdata[26];
   assign rd_light_doze_supported = cfg_rdata[25];
   assign rd_aux_current = cfg_rdata[24:22];
   assign rd_init_needed = cfg_rdata[21];
   assign rd_reserved = cfg_rdata[20];
   assign rd_wake_needs_bus_clock = cfg_rdata[19];
   assign rd_power_spec_revision = cfg_rdata[18:16];

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking pwm_cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_cap_read;
      cfg_rd && dw_sel;
   endsequence

   AST_NEXT_PTR: assert property (
      s_cap_read |=> cfg_rdata[15:8] == 8'h00 && cfg_hit)
      else $error("next pointer did not read as zero");

   AST_CAP_ID: assert property (
      s_cap_read |=> cfg_rdata[7:0] == 8'h01)
      else $error("capability identifier did not read as one");

   AST_WAKE_SRC: assert property (
      s_cap_read |=> cfg_rdata[30:27] == 4'hf)
      else $error("wake source field not all ones");

   AST_DEEP_DOZE: assert property (
      s_cap_read |=> cfg_rdata[26])
      else $error("deep doze support bit not set");

   AST_LIGHT_DOZE: assert property (
      s_cap_read |=> cfg_rdata[25])
      else $error("light doze support bit not set");

   AST_AUX_CURRENT: assert property (
      s_cap_read |=> (cfg_rdata[24:22] == (cfg_rdata[31] ? 3'h1 : 3'h0))
                     && (cfg_rdata[31] == $past(wake_from_cold_off)))
      else $error("auxiliary current does not follow cold-wake bit");

   AST_NO_INIT: assert property (
      s_cap_read |=> !cfg_rdata[21])
      else $error("initialization bit read as one");

   AST_RSVD_ZERO: assert property (
      s_cap_read |=> !cfg_rdata[20])
      else $error("reserved bit read as one");

   AST_NO_CLK: assert property (
      s_cap_read |=> !cfg_rdata[19])
      else $error("bus clock bit read as one");

   AST_REVISION: assert property (
      s_cap_read |=> cfg_rdata[18:16] == 3'h2)
      else $error("revision field not 010b");

   AST_COLD_HOLD: assert property (
      !cold_wake_load |=> $stable(wake_from_cold_off))
      else $error("cold-wake bit moved without internal load");

   AST_COLD_LOAD: assert property (
      cold_wake_load |=> wake_from_cold_off == $past(cold_wake_value))
      else $error("cold-wake bit missed an internal load");

   AST_COLD_RESET: assert property (
      $rose(rst_n) |-> !wake_from_cold_off)
      else $error("cold-wake bit not zero after reset");

   AST_WRITE_IGNORED: assert property (
      (cfg_wr && !cfg_rd && dw_sel && !cold_wake_load) ##[1:2] s_cap_read
         |=> cfg_rdata == {capw_value($past(wake_from_cold_off)), 16'h0001})
      else $error("write changed the capability registers");

   AST_WRITE_ACK: assert property (
      (cfg_wr && !cfg_rd) |=> cfg_ack && cfg_acc == PWM_ACC_WRITE
                             && cfg_rdata == 32'h0000_0000)
      else $error("write not answered plainly");

   AST_ACK_ONLY_ON_REQ: assert property (
      !any_req |=> !cfg_ack && !cfg_hit && cfg_acc == PWM_ACC_NONE)
      else $error("answer without request");

   AST_MISS_ZERO: assert property (
      (cfg_rd && !dw_sel) |=> cfg_ack && !cfg_hit && cfg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   AST_DEFAULT_DWORD: assert property (
      (cfg_rd && dw_sel && !wake_from_cold_off) |=> cfg_rdata == 32'h7e02_0001)
      else $error("reset dword wrong");

   AST_AUX_SELF: assert property (
      (cfg_rd && dw_sel && !wake_from_cold_off) |=> rd_aux_current == 3'h0)
      else $error("auxiliary current not self-powered");

   AST_AUX_55MA: assert property (
      (cfg_rd && dw_sel && wake_from_cold_off) |=> rd_aux_current == 3'h1)
      else $error("auxiliary current not 001b with cold wake");

   AST_COLD_DWORD: assert property (
      (cfg_rd && dw_sel && wake_from_cold_off) |=> cfg_rdata == 32'hfe42_0001)
      else $error("cold-wake dword wrong");

   AST_COLD_SHOWN: assert property (
      s_cap_read |=> rd_wake_from_cold_off == $past(wake_from_cold_off))
      else $error("read bit 15 differs from cold-wake bit");

   AST_HEADER_WORD: assert property (
      s_cap_read |=> rd_next_ptr == 8'h00 && rd_cap_list_identifier == 8'h01)
      else $error("capability header wrong");

   AST_FIXED_COLD: assert property (
      (cfg_rd && dw_sel && wake_from_cold_off) |=> rd_wake_source_states == 4'hf
         && rd_deep_doze_supported && rd_light_doze_supported)
      else $error("fixed support bits wrong with cold wake");

   AST_ZERO_BITS_COLD: assert property (
      (cfg_rd && dw_sel && wake_from_cold_off) |=> !rd_init_needed && !rd_reserved
         && !rd_wake_needs_bus_clock)
      else $error("zero bits set with cold wake");

   AST_REVISION_COLD: assert property (
      (cfg_rd && dw_sel && wake_from_cold_off) |=> rd_power_spec_revision == 3'h2)
      else $error("revision wrong with cold wake");

   AST_READ_ANSWER: assert property (
      s_cap_read |=> cfg_ack && cfg_hit && cfg_acc == PWM_ACC_READ)
      else $error("read not answered");

   AST_READ_WINS: assert property (
      (cfg_rd && cfg_wr) |=> cfg_acc == PWM_ACC_READ)
      else $error("write beat a read");

   AST_WRITE_HIT: assert property (
      (cfg_wr && dw_sel) |=> cfg_ack && cfg_hit)
      else $error("write to capability dword not hit");

   AST_WRITE_MISS: assert property (
      (cfg_wr && !dw_sel) |=> cfg_ack && !cfg_hit)
      else $error("unmapped write hit");

   AST_IDLE_RDATA: assert property (
      !cfg_rd |=> cfg_rdata == 32'h0000_0000)
      else $error("read data without read");

   AST_ACK_ON_REQ: assert property (
      any_req |=> cfg_ack)
      else $error("request not acknowledged");

   AST_HIT_WITH_ACK: assert property (
      cfg_hit |-> cfg_ack)
      else $error("hit without acknowledge");

   AST_DATA_ONLY_ON_HIT: assert property (
      (cfg_rdata != 32'h0000_0000) |-> cfg_hit && cfg_acc == PWM_ACC_READ)
      else $error("data outside a hit read");

   AST_AUX_TRACKS: assert property (
      (cfg_hit && cfg_acc == PWM_ACC_READ) |-> rd_aux_current == {2'b00, rd_wake_from_cold_off})
      else $error("auxiliary field not tied to bit 15");

   AST_ACC_LEGAL: assert property (
      cfg_acc == PWM_ACC_NONE || cfg_acc == PWM_ACC_READ || cfg_acc == PWM_ACC_WRITE)
      else $error("illegal access kind");

   AST_COLD_WRITE_BLOCKED: assert property (
      (cfg_wr && !cold_wake_load) |=> $stable(wake_from_cold_off))
      else $error("write moved the cold-wake bit");

   AST_COLD_READ_STABLE: assert property (
      (cfg_rd && !cold_wake_load) |=> $stable(wake_from_cold_off))
      else $error("read moved the cold-wake bit");

   AST_RESET_OUTPUTS: assert property (
      $rose(rst_n) |-> !cfg_ack && !cfg_hit && cfg_acc == PWM_ACC_NONE
         && cfg_rdata == 32'h0000_0000)
      else $error("outputs not idle after reset");

   AST_ACC_WRITE_ONLY: assert property (
      (cfg_acc == PWM_ACC_WRITE) |-> cfg_ack && cfg_rdata == 32'h0000_0000)
      else $error("write answer carried data");

   COV_READ_DEFAULT: cover property (
      s_cap_read ##1 cfg_rdata == 32'h7e02_0001);

   COV_READ_COLD: cover property (
      cold_wake_load && cold_wake_value ##[1:2] s_cap_read ##1 cfg_rdata[31]);

   COV_WRITE_THEN_READ: cover property (
      (cfg_wr && dw_sel && wr_data_seen) ##[1:2] s_cap_read);

   COV_READ_AFTER_RESET: cover property (
      $rose(rst_n) ##[1:3] s_cap_read);

   COV_MISS: cover property (
      cfg_rd && !dw_sel);

endmodule : pwm_cap

// ---- pwm_host.sv ----
// host configuration software model: one config cycle at a time.
// assumes the block takes a request on the edge after it is driven.
`timescale 1ns/10ps
module pwm_host
   import pwm_pkg::*;
(
   input wire logic clk_sys,
   output logic cfg_rd = 1'b0,
   output logic cfg_wr = 1'b0,
   output pwm_addr_t cfg_addr = 8'h00,
   output pwm_dword_t cfg_wdata = 32'h0000_0000
);
   // released strobes drop to zero and address and data flip so stale values never look valid
   task automatic xfer(input logic wr, input pwm_addr_t a, input pwm_dword_t d);
      @(posedge clk_sys);
      cfg_rd <= ~wr;
      cfg_wr <= wr;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge clk_sys);
      cfg_rd <= 1'b0;
      cfg_wr <= 1'b0;
      cfg_addr <= ~a;
      cfg_wdata <= ~d;
   endtask : xfer
endmodule : pwm_host

// ---- tb.sv ----
// bench for the power-management capability registers.
// assumes pwm_host makes config cycles; bench drives the cold-wake strobe.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb
   import pwm_pkg::*;
;
   logic clk_sys, rst_n, cfg_rd, cfg_wr, cold_wake_load, cold_wake_value;
   logic cfg_ack, cfg_hit, wake_from_cold_off;
   pwm_addr_t cfg_addr;
   pwm_dword_t cfg_wdata, cfg_rdata;
   pwm_acc_t cfg_acc;
   int n_fail = 0, n_checks = 0, cyc = 0;
   pwm_host host (.clk_sys(clk_sys), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata));
   pwm_cap uut (.clk_sys(clk_sys), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cold_wake_load(cold_wake_load),
      .cold_wake_value(cold_wake_value), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
      .cfg_hit(cfg_hit), .cfg_acc(cfg_acc), .wake_from_cold_off(wake_from_cold_off));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic give_verdict();
      if (n_fail == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 500) begin
         n_fail++;
         give_verdict();
      end
   end
   // answer is settled just after the taking edge
   task automatic rd(input pwm_addr_t a);
      host.xfer(1'b0, a, 32'h0000_0000);
      #1;
   endtask : rd
   task automatic wake(input logic v);
      @(posedge clk_sys);
      cold_wake_load <= 1'b1;
      cold_wake_value <= v;
      @(posedge clk_sys);
      cold_wake_load <= 1'b0;
      cold_wake_value <= ~v;
      #1;
   endtask : wake
   // every byte address of the dword returns the same pair
   task automatic t_defaults();
      for (int i = 4; i < 8; i++) begin
         rd(8'h40 + 8'(i));
         `CHK("ack", 1'b1, cfg_ack)
         `CHK("hit", 1'b1, cfg_hit)
         `CHK("acc", PWM_ACC_READ, cfg_acc)
         `CHK("dword", 32'h7e02_0001, cfg_rdata)
      end
   endtask : t_defaults
   // all-ones writes must not reach bit 15 or any fixed field
   task automatic t_write();
      for (int i = 0; i < 2; i++) begin
         host.xfer(1'b1, 8'h44 + 8'(2 * i), 32'hffff_ffff);
         #1;
         `CHK("wr acc", PWM_ACC_WRITE, cfg_acc)
         `CHK("wr ack", 1'b1, cfg_ack)
         `CHK("wr hit", 1'b1, cfg_hit)
         `CHK("wr data", 32'h0000_0000, cfg_rdata)
      end
      rd(8'h46);
      `CHK("after wr", 32'h7e02_0001, cfg_rdata)
   endtask : t_write
   task automatic t_unmapped();
      rd(8'h48);
      `CHK("unm hit", 1'b0, cfg_hit)
      `CHK("unm ack", 1'b1, cfg_ack)
      `CHK("unm acc", PWM_ACC_READ, cfg_acc)
      `CHK("unm data", 32'h0000_0000, cfg_rdata)
   endtask : t_unmapped
   task automatic t_cold();
      wake(1'b1);
      `CHK("cold bit", 1'b1, wake_from_cold_off)
      rd(8'h46);
      `CHK("cold dword", 32'hfe42_0001, cfg_rdata)
      wake(1'b0);
      rd(8'h44);
      `CHK("self dword", 32'h7e02_0001, cfg_rdata)
      wake(1'b1);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      `CHK("cold rst", 1'b0, wake_from_cold_off)
      `CHK("rst ack", 1'b0, cfg_ack)
      rd(8'h46);
      `CHK("rst dword", 32'h7e02_0001, cfg_rdata)
   endtask : t_cold
   initial begin
      rst_n = 1'b0;
      cold_wake_load = 1'b0;
      cold_wake_value = 1'b0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_defaults();
      t_write();
      t_unmapped();
      t_cold();
      give_verdict();
   end
endmodule : tb
